// ==== bench/tcs_top_checker.sv ====
// Port checker for the timer command and status block
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"
module tcs_checker #(
    parameter int ADDR_W = 8
) (
    input wire logic              clock,
    input wire logic              sys_rst,
    input wire logic [ADDR_W-1:0] reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic [2:0]        chan_mode_wr,
    input wire logic [5:0]        chan_mode_wdata,
    input wire logic [2:0]        capture_push,
    input wire logic [2:0]        chan_buffer_wr,
    input wire logic              update_evt,
    input wire logic              top_wr,
    input wire logic              top_buffer_wr,
    input wire logic              timer_running,
    input wire logic              count_dir_down,
    input wire logic              top_buffer_valid,
    input wire logic              top_buffer_move,
    input wire logic [2:0]        chan_polarity,
    input wire logic [2:0]        chan_capture_valid,
    input wire logic [2:0]        chan_buffer_valid,
    input wire logic              start_pulse,
    input wire logic              stop_pulse,
    input wire logic [2:0]        chan_buffer_move
);
    // Decoded accesses and the status word as it should read
    wire logic cmd_wr = reg_wr && reg_addr == ADDR_W'(`TCS_OFF_CMD);
    wire logic st_rd = reg_rd && reg_addr == ADDR_W'(`TCS_OFF_STATUS);
    wire logic go = cmd_wr && reg_wdata[1:0] == 2'h1;
    wire logic off0 = chan_mode_wr[0] && chan_mode_wdata[1:0] == `TCS_MODE_OFF
        && !capture_push[0] && !chan_buffer_wr[0];
    wire logic [31:0] st = {5'h00, chan_polarity, 5'h00, chan_capture_valid, 5'h00,
        chan_buffer_valid, 5'h00, top_buffer_valid, count_dir_down, timer_running};

    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    // Run state against commands
    property p_start;
        go |=> timer_running;
    endproperty
    a_start: assert property (p_start) else $error("start did not run");
    property p_stop;
        cmd_wr && reg_wdata[1] |=> !timer_running;
    endproperty
    a_stop: assert property (p_stop) else $error("stop did not halt");
    property p_hold;
        $rose(timer_running) |-> $past(go);
    endproperty
    a_hold: assert property (p_hold) else $error("run began without start");

    // Read data timing and content
    property p_idle;
        !st_rd |=> reg_rdata == 32'h0000_0000;
    endproperty
    a_idle: assert property (p_idle) else $error("read data not zero");
    property p_status;
        st_rd |=> reg_rdata == $past(st);
    endproperty
    a_status: assert property (p_status) else $error("status word wrong");

    // Flag clearing and top buffer moves
    property p_off;
        off0 |=> !chan_polarity[0] && !chan_capture_valid[0] && !chan_buffer_valid[0];
    endproperty
    a_off: assert property (p_off) else $error("off write kept flags");
    property p_top_clr;
        top_wr && !top_buffer_wr |-> ##1 !top_buffer_valid;
    endproperty
    a_top_clr: assert property (p_top_clr) else $error("top write kept flag");
    property p_top_move;
        update_evt && top_buffer_valid && !top_wr && !top_buffer_wr
            |=> top_buffer_move && !top_buffer_valid;
    endproperty
    a_top_move: assert property (p_top_move) else $error("top move missing");

    // Command pulses and channel buffer moves
    property p_start_pulse;
        go |=> start_pulse && !stop_pulse;
    endproperty
    a_start_pulse: assert property (p_start_pulse) else $error("start pulse missing");
    property p_stop_pulse;
        cmd_wr && reg_wdata[1] |=> stop_pulse && !start_pulse;
    endproperty
    a_stop_pulse: assert property (p_stop_pulse) else $error("stop pulse missing");
    property p_no_pulse;
        !cmd_wr |=> !start_pulse && !stop_pulse;
    endproperty
    a_no_pulse: assert property (p_no_pulse) else $error("pulse without command");
    property p_buf_move;
        chan_buffer_move != 3'h0
            |-> $past(update_evt) && (chan_buffer_move & ~$past(chan_buffer_valid)) == 3'h0;
    endproperty
    a_buf_move: assert property (p_buf_move) else $error("buffer move unasked");

    // Main scenarios reached
    c_start: cover property (go);
    c_top_move: cover property (top_buffer_move);
    c_off: cover property (off0);
endmodule

bind tcs_top tcs_checker #(.ADDR_W(ADDR_W)) u_tcs_checker (
    .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_mode_wr(chan_mode_wr),
    .chan_mode_wdata(chan_mode_wdata), .capture_push(capture_push),
    .chan_buffer_wr(chan_buffer_wr), .update_evt(update_evt), .top_wr(top_wr),
    .top_buffer_wr(top_buffer_wr), .timer_running(timer_running),
    .count_dir_down(count_dir_down), .top_buffer_valid(top_buffer_valid),
    .top_buffer_move(top_buffer_move), .chan_polarity(chan_polarity),
    .chan_capture_valid(chan_capture_valid), .chan_buffer_valid(chan_buffer_valid),
    .start_pulse(start_pulse), .stop_pulse(stop_pulse), .chan_buffer_move(chan_buffer_move)
);
`default_nettype wire

// ==== bench/timer_command_status_regs_test.sv ====
// Self-checking bench for the timer command and status block
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"
module timer_command_status_regs_test;
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic [31:0] reg_wdata = 32'h0000_0000;
    logic        reg_wr = 1'b0, reg_rd = 1'b0, update_evt = 1'b0, top_wr = 1'b0;
    logic        top_buffer_wr = 1'b0, count_down = 1'b0, core_halt = 1'b0;
    logic [2:0]  chan_mode_wr = 3'h0, capture_push = 3'h0, capture_edge_fall = 3'h0;
    logic [2:0]  capture_pop = 3'h0, chan_input_level = 3'h0, chan_buffer_wr = 3'h0;
    logic [5:0]  chan_mode_wdata = 6'h00;
    logic [31:0] reg_rdata;
    logic        timer_running, start_pulse, stop_pulse, count_dir_down;
    logic        top_buffer_valid, top_buffer_move, exp_run = 1'b0, exp_dir = 1'b0;
    logic [2:0]  chan_polarity, chan_capture_valid, chan_buffer_valid, chan_buffer_move;
    logic [2:0]  b, z = 3'h0;
    int          fails = 0, samples_checked = 0, cycles = 0;

    always #12.5 clock = ~clock;
    tcs_top dut (
        .clock(clock), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .chan_mode_wr(chan_mode_wr),
        .chan_mode_wdata(chan_mode_wdata), .capture_push(capture_push),
        .capture_edge_fall(capture_edge_fall), .capture_pop(capture_pop),
        .chan_input_level(chan_input_level), .chan_buffer_wr(chan_buffer_wr),
        .update_evt(update_evt), .top_wr(top_wr), .top_buffer_wr(top_buffer_wr),
        .count_down(count_down), .core_halt(core_halt), .timer_running(timer_running),
        .start_pulse(start_pulse), .stop_pulse(stop_pulse), .count_dir_down(count_dir_down),
        .top_buffer_valid(top_buffer_valid), .top_buffer_move(top_buffer_move),
        .chan_polarity(chan_polarity), .chan_capture_valid(chan_capture_valid),
        .chan_buffer_valid(chan_buffer_valid), .chan_buffer_move(chan_buffer_move)
    );

    // Cycle ceiling against hangs
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            test_done();
        end
    end

    task test_done;
        $display("checks %0d mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // Register write, and read compared in the cycle after the strobe
    task wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clock);
        reg_wr <= 1'b0;
    endtask
    task rd(input string w, input logic [7:0] a, input logic [31:0] e);
        @(posedge clock);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clock);
        reg_rd <= 1'b0;
        #1 chk(w, e, reg_rdata);
    endtask
    // One comparison of a settled value against its expectation
    task chk(input string w, input logic [31:0] e, s);
        samples_checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", w, e, s);
        end
    endtask
    task rs(input string w, input logic [2:0] p, c, v, input logic t);
        rd(w, `TCS_OFF_STATUS, {5'h00, p, 5'h00, c, 5'h00, v, 5'h00, t, exp_dir, exp_run});
    endtask

    // One-cycle pulses, k = {halt, top buffer wr, top wr, update, buffer wr, pop, push}
    task ev(input int ch, input logic [6:0] k);
        @(posedge clock);
        {core_halt, top_buffer_wr, top_wr, update_evt} <= k[6:3];
        {chan_buffer_wr[ch], capture_pop[ch], capture_push[ch]} <= k[2:0];
        @(posedge clock);
        {core_halt, top_buffer_wr, top_wr, update_evt} <= 4'h0;
        {chan_buffer_wr, capture_pop, capture_push} <= 9'h000;
    endtask
    task mode(input int ch, input logic [1:0] m);
        @(posedge clock);
        chan_mode_wr[ch] <= 1'b1;
        chan_mode_wdata[2*ch +: 2] <= m;
        @(posedge clock);
        chan_mode_wr <= 3'h0;
    endtask
    task lv(input int ch, input logic l, f);
        @(posedge clock);
        chan_input_level[ch] <= l;
        capture_edge_fall[ch] <= f;
    endtask

    // Test sequence
    initial begin
        repeat (12) @(posedge clock);
        sys_rst <= 1'b0;
        rs("status reset", z, z, z, 1'b0);
        rd("cmd readback", `TCS_OFF_CMD, 32'h0000_0000);
        rd("unmapped", 8'h0C, 32'h0000_0000);
        $display("reset test done");
        wr(`TCS_OFF_CMD, 32'h0000_0001);
        exp_run = 1'b1;
        wr(`TCS_OFF_CMD, 32'h0000_0000);
        wr(`TCS_OFF_STATUS, 32'hFFFF_FFFF);
        wr(8'h0C, 32'h0000_0002);
        rs("run held", z, z, z, 1'b0);
        rd("cmd after start", `TCS_OFF_CMD, 32'h0000_0000);
        wr(`TCS_OFF_CMD, 32'h0000_0002);
        exp_run = 1'b0;
        rs("run stopped", z, z, z, 1'b0);
        wr(`TCS_OFF_CMD, 32'h0000_0001);
        wr(`TCS_OFF_CMD, 32'h0000_0003);
        rs("stop beats start", z, z, z, 1'b0);
        wr(`TCS_OFF_CMD, 32'h0000_0001);
        ev(0, 7'h40);
        rs("core halt", z, z, z, 1'b0);
        wr(`TCS_OFF_CMD, 32'h0000_0001);
        exp_run = 1'b1;
        @(posedge clock);
        count_down <= 1'b1;
        exp_dir = 1'b1;
        rs("running down", z, z, z, 1'b0);
        $display("run test done");
        ev(0, 7'h20);
        rs("top buffer set", z, z, z, 1'b1);
        ev(0, 7'h08);
        #1 chk("top move", 32'h0000_0001, top_buffer_move);
        rs("top buffer moved", z, z, z, 1'b0);
        ev(0, 7'h20);
        ev(0, 7'h10);
        rs("top direct write", z, z, z, 1'b0);
        $display("top test done");
        for (int ch = 0; ch < 3; ch++) begin
            b = 3'h1 << ch;
            mode(ch, `TCS_MODE_COMPARE);
            ev(ch, 7'h04);
            rs("buffer valid", z, z, b, 1'b0);
            ev(ch, 7'h08);
            #1 chk("buffer move", b, chan_buffer_move);
            rs("buffer moved", z, z, z, 1'b0);
            ev(ch, 7'h04);
            mode(ch, `TCS_MODE_OFF);
            rs("buffer off", z, z, z, 1'b0);
            lv(ch, 1'b1, 1'b1);
            mode(ch, `TCS_MODE_PWM);
            rs("input polarity", b, z, z, 1'b0);
            mode(ch, `TCS_MODE_OFF);
            rs("polarity off", z, z, z, 1'b0);
            mode(ch, `TCS_MODE_CAPTURE);
            ev(ch, 7'h01);
            rs("falling capture", b, b, z, 1'b0);
            lv(ch, 1'b0, 1'b0);
            ev(ch, 7'h01);
            rs("rising capture", z, b, z, 1'b0);
            ev(ch, 7'h02);
            ev(ch, 7'h02);
            rs("capture empty", z, z, z, 1'b0);
            lv(ch, 1'b0, 1'b1);
            ev(ch, 7'h01);
            mode(ch, `TCS_MODE_OFF);
            rs("capture off", z, z, z, 1'b0);
            $display("channel %0d test done", ch);
        end
        test_done();
    end
endmodule
`default_nettype wire

// ==== core/tcs_chan.sv ====
// Per-channel polarity, capture valid and buffer valid status
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"

module tcs_chan
    import tcs_pkg::*;
#(
    parameter int CAP_DEPTH = `TCS_CAP_DEPTH
) (
    input  wire logic       clock,
    input  wire logic       sys_rst,
    input  wire logic       mode_wr,
    input  wire logic [1:0] mode_wdata,
    input  wire logic       capture_push,
    input  wire logic       capture_edge_fall,
    input  wire logic       capture_pop,
    input  wire logic       input_level,
    input  wire logic       buffer_wr,
    input  wire logic       update_evt,
    output var  logic       polarity,
    output var  logic       capture_valid,
    output var  logic       buffer_valid,
    output var  logic       buffer_move
);

    localparam int OCC_W = $clog2(CAP_DEPTH + 1);
    localparam logic [OCC_W-1:0] OCC_FULL = OCC_W'(CAP_DEPTH);
    localparam logic [OCC_W-1:0] OCC_ONE  = OCC_W'(1);

    tcs_mode_t        mode_q;
    logic [OCC_W-1:0] occ_q;
    logic [OCC_W-1:0] occ_d;
    logic             mode_off_wr;
    logic             is_capture;
    logic             is_compare;
    logic             push_ok;

    // Mode decode
    assign mode_off_wr = mode_wr && (mode_wdata == `TCS_MODE_OFF);
    assign is_capture  = (mode_q == TCS_MODE_CAPTURE_E);
    assign is_compare  = (mode_q == TCS_MODE_COMPARE_E) || (mode_q == TCS_MODE_PWM_E);
    assign push_ok     = capture_push && is_capture;

    // Shadow of the channel mode field
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_q <= TCS_MODE_OFF_E;
        end else if (mode_wr) begin
            mode_q <= tcs_mode_t'(mode_wdata);
        end
    end

    // Capture FIFO fill level; a push when full holds the level at full
    always_comb begin
        occ_d = occ_q;
        if (push_ok && !(capture_pop && occ_q != '0)) begin
            if (occ_q != OCC_FULL) begin
                occ_d = occ_q + OCC_ONE;
            end
        end else if (!push_ok && capture_pop && occ_q != '0) begin
            occ_d = occ_q - OCC_ONE;
        end
        if (mode_off_wr) begin
            occ_d = push_ok ? OCC_ONE : '0;   // see R7
        end
    end

    // Fill level and its registered not-empty flag
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            occ_q         <= '0;
            capture_valid <= 1'b0;
        end else begin
            occ_q         <= occ_d;
            capture_valid <= (occ_d != '0);   // see R6
        end
    end

    // Polarity: capture edge, else selected input level, cleared on off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            polarity <= 1'b0;
        end else if (push_ok) begin
            polarity <= capture_edge_fall;    // see R3 see R4
        end else if (mode_off_wr) begin
            polarity <= 1'b0;                 // see R5
        end else if (is_compare) begin
            polarity <= input_level;          // see R3 see R4
        end
    end

    // Buffer valid: set by a buffer write in compare or PWM, cleared by update or off
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            buffer_valid <= 1'b0;
        end else if (buffer_wr && is_compare) begin
            buffer_valid <= 1'b1;             // see R8
        end else if (update_evt || mode_off_wr) begin
            buffer_valid <= 1'b0;             // see R8 see R9
        end
    end

    // Pulse telling the unit to move buffer into value register
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            buffer_move <= 1'b0;
        end else begin
            buffer_move <= update_evt && buffer_valid && is_compare; // see R8
        end
    end

endmodule

`default_nettype wire

// ==== core/tcs_defs.svh ====
// Register offsets, status field positions, mode encodings and reset values
`ifndef TCS_DEFS_SVH
`define TCS_DEFS_SVH

// Register byte offsets
`define TCS_OFF_CMD      8'h04
`define TCS_OFF_STATUS   8'h08

// Command bit positions
`define TCS_CMD_START    0
`define TCS_CMD_STOP     1

// Status bit positions (channel fields give the lowest bit)
`define TCS_ST_RUNNING   0
`define TCS_ST_DIR       1
`define TCS_ST_TOP_BUFFER_VALID     2
`define TCS_ST_BUFV_LO   8
`define TCS_ST_CAPV_LO   16
`define TCS_ST_POL_LO    24

// Channel mode field encodings
`define TCS_MODE_OFF     2'h0
`define TCS_MODE_CAPTURE 2'h1
`define TCS_MODE_COMPARE 2'h2
`define TCS_MODE_PWM     2'h3

// Run state encodings
`define TCS_RUN_IDLE     1'h0
`define TCS_RUN_ACTIVE   1'h1

// Sizes and reset values
`define TCS_NUM_CH       3
`define TCS_CAP_DEPTH    2
`define TCS_WORD_ZERO    32'h0000_0000

`endif

// ==== core/tcs_pkg.sv ====
// Types shared by the timer command and status logic
`default_nettype none
`include "tcs_defs.svh"

package tcs_pkg;

    // Channel mode field
    typedef enum logic [1:0] {
        TCS_MODE_OFF_E     = `TCS_MODE_OFF,
        TCS_MODE_CAPTURE_E = `TCS_MODE_CAPTURE,
        TCS_MODE_COMPARE_E = `TCS_MODE_COMPARE,
        TCS_MODE_PWM_E     = `TCS_MODE_PWM
    } tcs_mode_t;

    // Counter run state
    typedef enum logic {
        TCS_RUN_IDLE_E   = `TCS_RUN_IDLE,
        TCS_RUN_ACTIVE_E = `TCS_RUN_ACTIVE
    } tcs_run_t;

endpackage

`default_nettype wire

// ==== core/tcs_run.sv ====
// Run state of the counter, driven by one-shot start and stop commands
`timescale 1ns/10ps
`default_nettype none

module tcs_run
    import tcs_pkg::*;
(
    input  wire logic clock,
    input  wire logic sys_rst,
    input  wire logic start_cmd,
    input  wire logic stop_cmd,
    input  wire logic core_halt,
    output var  logic running,
    output var  logic start_pulse,
    output var  logic stop_pulse
);

    tcs_run_t state_q;
    tcs_run_t state_d;

    // Next state: stop beats start, start beats a halt from the core
    always_comb begin
        state_d = state_q;
        case (state_q)
            TCS_RUN_IDLE_E: begin
                if (start_cmd && !stop_cmd) begin
                    state_d = TCS_RUN_ACTIVE_E;   // see R1
                end
            end
            TCS_RUN_ACTIVE_E: begin
                if (stop_cmd || (core_halt && !start_cmd)) begin
                    state_d = TCS_RUN_IDLE_E;     // see R2
                end
            end
            default: begin
                state_d = TCS_RUN_IDLE_E;
            end
        endcase
    end

    // State register; zero command bits leave it alone
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_q <= TCS_RUN_IDLE_E;
        end else begin
            state_q <= state_d;               // see R12
        end
    end

    // Registered run level for the status word
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            running <= 1'b0;
        end else begin
            running <= (state_d == TCS_RUN_ACTIVE_E);
        end
    end

    // One-cycle command pulses to the counter core
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
        end else begin
            start_pulse <= start_cmd && !stop_cmd; // see R1
            stop_pulse  <= stop_cmd;               // see R2
        end
    end

endmodule

`default_nettype wire

// ==== core/tcs_top.sv ====
// Timer command and status registers with per-channel status flags
//
// Summary of operation
// R1 - Writing one to command bit 0 starts the timer; bit reads zero.
// R2 - Writing one to command bit 1 stops the timer; nothing stored.
// R3 - Bits 24-26: capture edge polarity, or selected input level in compare.
// R4 - Polarity reads 0 for low or rising, 1 for high or falling.
// R5 - Polarity bit clears when the channel mode is written to off; a capture push in the same cycle sets it to the capture edge instead.
// R6 - Bits 16-18: capture valid, set while the capture FIFO is not empty.
// R7 - Capture valid used in capture mode, cleared on mode write to off; a capture push in the same cycle leaves one entry and the flag set.
// R8 - Bits 8-10: buffer valid until the next update moves the buffer.
// R9 - Buffer valid used in compare or PWM, cleared on mode off write; a buffer write in the same cycle sets it instead.
// R10 - Bit 2: top buffer valid until the next update moves it.
// R11 - Top buffer valid also clears on a direct top register write.
// R12 - Status writes ignored; zero command bits leave run state unchanged.
//
// Added by the designer: the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "tcs_defs.svh"

module tcs_top
    import tcs_pkg::*;
#(
    parameter int ADDR_W    = 8,
    parameter int CAP_DEPTH = `TCS_CAP_DEPTH
) (
    input  wire logic                         clock,
    input  wire logic                         sys_rst,
    input  wire logic [ADDR_W-1:0]            reg_addr,
    input  wire logic [31:0]                  reg_wdata,
    input  wire logic                         reg_wr,
    input  wire logic                         reg_rd,
    output var  logic [31:0]                  reg_rdata,
    input  wire logic [`TCS_NUM_CH-1:0]       chan_mode_wr,
    input  wire logic [2*`TCS_NUM_CH-1:0]     chan_mode_wdata,
    input  wire logic [`TCS_NUM_CH-1:0]       capture_push,
    input  wire logic [`TCS_NUM_CH-1:0]       capture_edge_fall,
    input  wire logic [`TCS_NUM_CH-1:0]       capture_pop,
    input  wire logic [`TCS_NUM_CH-1:0]       chan_input_level,
    input  wire logic [`TCS_NUM_CH-1:0]       chan_buffer_wr,
    input  wire logic                         update_evt,
    input  wire logic                         top_wr,
    input  wire logic                         top_buffer_wr,
    input  wire logic                         count_down,
    input  wire logic                         core_halt,
    output var  logic                         timer_running,
    output var  logic                         start_pulse,
    output var  logic                         stop_pulse,
    output var  logic                         count_dir_down,
    output var  logic                         top_buffer_valid,
    output var  logic                         top_buffer_move,
    output var  logic [`TCS_NUM_CH-1:0]       chan_polarity,
    output var  logic [`TCS_NUM_CH-1:0]       chan_capture_valid,
    output var  logic [`TCS_NUM_CH-1:0]       chan_buffer_valid,
    output var  logic [`TCS_NUM_CH-1:0]       chan_buffer_move
);

    localparam logic [ADDR_W-1:0] ADDR_CMD    = ADDR_W'(`TCS_OFF_CMD);
    localparam logic [ADDR_W-1:0] ADDR_STATUS = ADDR_W'(`TCS_OFF_STATUS);

    logic        cmd_hit;
    logic        start_cmd;
    logic        stop_cmd;
    logic        status_hit;
    logic [31:0] status_word;

    // Command decode: one-shot, never stored
    assign cmd_hit   = reg_wr && (reg_addr == ADDR_CMD);
    assign start_cmd = cmd_hit && reg_wdata[`TCS_CMD_START]; // see R1
    assign stop_cmd  = cmd_hit && reg_wdata[`TCS_CMD_STOP];  // see R2
    assign status_hit = reg_rd && (reg_addr == ADDR_STATUS);

    // Run state machine and command pulses
    tcs_run u_run (
        .clock       (clock),
        .sys_rst     (sys_rst),
        .start_cmd   (start_cmd),
        .stop_cmd    (stop_cmd),
        .core_halt   (core_halt),
        .running     (timer_running),
        .start_pulse (start_pulse),
        .stop_pulse  (stop_pulse)
    );

    // Per-channel status logic
    genvar ch;
    generate
        for (ch = 0; ch < `TCS_NUM_CH; ch++) begin : g_chan
            tcs_chan #(
                .CAP_DEPTH (CAP_DEPTH)
            ) u_chan (
                .clock             (clock),
                .sys_rst           (sys_rst),
                .mode_wr           (chan_mode_wr[ch]),
                .mode_wdata        (chan_mode_wdata[2*ch +: 2]),
                .capture_push      (capture_push[ch]),
                .capture_edge_fall (capture_edge_fall[ch]),
                .capture_pop       (capture_pop[ch]),
                .input_level       (chan_input_level[ch]),
                .buffer_wr         (chan_buffer_wr[ch]),
                .update_evt        (update_evt),
                .polarity          (chan_polarity[ch]),
                .capture_valid     (chan_capture_valid[ch]),
                .buffer_valid      (chan_buffer_valid[ch]),
                .buffer_move       (chan_buffer_move[ch])
            );
        end
    endgenerate

    // Top buffer valid: a new write wins over update or direct top write
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            top_buffer_valid <= 1'b0;
        end else if (top_buffer_wr) begin
            top_buffer_valid <= 1'b1;             // see R10
        end else if (update_evt || top_wr) begin
            top_buffer_valid <= 1'b0;             // see R10 see R11
        end
    end

    // Pulse telling the unit to move top buffer into top value
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            top_buffer_move <= 1'b0;
        end else begin
            top_buffer_move <= update_evt && top_buffer_valid && !top_wr; // see R10
        end
    end

    // Count direction as reported by the counter core
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            count_dir_down <= 1'b0;
        end else begin
            count_dir_down <= count_down;
        end
    end

    // Status word assembly; reserved bits read zero
    always_comb begin
        status_word = `TCS_WORD_ZERO;
        status_word[`TCS_ST_RUNNING] = timer_running;
        status_word[`TCS_ST_DIR]     = count_dir_down;
        status_word[`TCS_ST_TOP_BUFFER_VALID]   = top_buffer_valid;                 // see R10
        status_word[`TCS_ST_BUFV_LO +: `TCS_NUM_CH] = chan_buffer_valid;  // see R8
        status_word[`TCS_ST_CAPV_LO +: `TCS_NUM_CH] = chan_capture_valid; // see R6
        status_word[`TCS_ST_POL_LO +: `TCS_NUM_CH]  = chan_polarity;      // see R3
    end

    // Read data for one cycle only; command and unmapped read zero
    always_ff @(posedge clock) begin
        if (sys_rst) begin
            reg_rdata <= `TCS_WORD_ZERO;
        end else if (status_hit) begin
            reg_rdata <= status_word;
        end else begin
            reg_rdata <= `TCS_WORD_ZERO;          // see R1
        end
    end

    // Writes to the status offset or unmapped offsets have no effect: see R12

endmodule

`default_nettype wire
